// *** dv/scs_host_model.sv ***
// host processor model issuing memory and I/O cycles to the block
// assumes one-cycle requests taken on a rising edge and answered one cycle later
`timescale 1ns/1ps
module scs_host_model (
  // clock
  input wire logic clock,
  // host cycles
  output scs_pkg::scs_host_req_type host_req,
  input wire logic host_ack,
  input wire logic host_forward,
  input wire logic [31:0] host_rdata
);
  import scs_pkg::*;
  logic [31:0] rd_seen;
  logic fwd_seen, ack_seen;
  logic [31:0] cfg_last;
  initial host_req = '0;
  // released fields show the inverse of the last value
  task automatic cycle(input logic io, input logic wr, input logic [31:0] ad, input logic [31:0] d);
    @(negedge clock);
    host_req <= {1'b1, io, wr, ad, d};
    @(posedge clock);
    @(negedge clock);
    ack_seen = host_ack;
    fwd_seen = host_forward;
    rd_seen = host_rdata;
    host_req <= {1'b0, ~io, ~wr, ~ad, ~d};
  endtask
  task automatic cfg_write(input logic [31:0] w);
    cfg_last = (w & 32'h1AD0FFFF) | 32'h00102000;
    if (cfg_last[9:8] == SCS_CLK_40)
      cfg_last[SCS_CFG_FAST_VL] = 1'b0;
    cycle(1'b0, 1'b1, SCS_CFG_ADDR, cfg_last);
  endtask
endmodule

// *** dv/scs_system_config_assertions.sv ***
// checker for the configuration word and legacy port block
// assumes it is bound into scs_system_config and sees only its ports
`timescale 1ns/1ps
module scs_system_config_assertions #(
  parameter int KBD_DELAY_CYCLES = scs_pkg::SCS_KBD_DELAY_CYCLES,
  parameter int FAST_DELAY_CYCLES = scs_pkg::SCS_FAST_DELAY_CYCLES,
  parameter int PULSE_CYCLES = scs_pkg::SCS_RESET_PULSE_CYCLES
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // host and snoop side
  input scs_pkg::scs_host_req_type host_req,
  input wire logic host_ack,
  input wire logic host_forward,
  input wire logic [31:0] host_rdata,
  input wire logic isa_io_write,
  input wire logic [15:0] isa_io_addr,
  input wire logic [7:0] isa_io_data,
  input wire logic turbo_mode,
  // system outputs
  input wire logic nmi_n,
  input wire logic address_line20_gate,
  input wire logic processor_reset_n,
  input wire logic speaker_enable,
  input wire logic timer2_gate,
  input wire logic flash_write_enable,
  input wire logic flash_read_enable,
  input scs_pkg::scs_dram_timing_type dram_timing
);
  import scs_pkg::*;
  // ----------
  // shadow of what the host has written
  // ----------
  logic [31:0] cfg_s;
  logic mask_s, p92a, kgate_s, kpend_s, hold_s;
  logic [15:0] low_cnt;
  wire [31:0] a = host_req.addr;
  wire io_wr = host_req.valid && host_req.is_io && host_req.write;
  wire cfg_wr = host_req.valid && !host_req.is_io && host_req.write && a == SCS_CFG_ADDR;
  wire p92_on = cfg_s[SCS_CFG_P92_EN];
  wire p92_rd = host_req.valid && host_req.is_io && !host_req.write && a == 32'h92 && p92_on;
  wire claimed = host_req.is_io ? (a == 32'h61 || (a == 32'h92 && p92_on)) : a == SCS_CFG_ADDR;
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      cfg_s <= SCS_CFG_RESET;
      {mask_s, p92a, kgate_s, kpend_s, hold_s} <= 5'h00;
      low_cnt <= 16'h0000;
    end else begin
      if (cfg_wr)
        cfg_s <= host_req.wdata;
      if (io_wr && a == 32'h70)
        mask_s <= host_req.wdata[7];
      if (isa_io_write && isa_io_addr == SCS_PORT_NMI_MASK)
        mask_s <= isa_io_data[7];
      if (io_wr && a == 32'h92 && p92_on)
        p92a <= host_req.wdata[1];
      if (io_wr && a == 32'h64)
        kpend_s <= host_req.wdata[7:0] == SCS_KBD_CMD_WRITE_OUT;
      if (io_wr && a == 32'h60 && kpend_s) begin
        kgate_s <= host_req.wdata[1];
        hold_s <= !host_req.wdata[0];
      end
      low_cnt <= processor_reset_n ? 16'h0000 : low_cnt + 16'h0001;
    end
  end
  // ----------
  // properties
  // ----------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  sequence fast_trig;
    io_wr && a == 32'h92 && p92_on && host_req.wdata[0] && processor_reset_n;
  endsequence
  sequence kbd_trig;
    io_wr && a == 32'h64 && host_req.wdata[7:4] == SCS_KBD_RESET_HI && !host_req.wdata[0];
  endsequence
  sequence held_then_low;
    processor_reset_n ##1 !processor_reset_n;
  endsequence
  ack_route_a: assert property (
    host_req.valid |=> host_ack && host_forward == !$past(claimed))
    else $error("bad host answer");
  p61_ctl_a: assert property (
    io_wr && a == 32'h61 |=> {speaker_enable, timer2_gate} == $past(host_req.wdata[1:0]))
    else $error("bad port 61h control");
  p92_read_a: assert property (
    p92_rd |=> host_rdata[5:2] == {2'b11, !$past(mask_s), $past(turbo_mode)})
    else $error("bad port 92h status");
  a20_or_a: assert property (address_line20_gate == (p92a | kgate_s))
    else $error("bad a20 gate");
  nmi_cause_a: assert property (
    !nmi_n |-> $past(cfg_s[SCS_CFG_PARITY_EN]) && !$past(mask_s))
    else $error("bad nmi");
  fast_delay_a: assert property (fast_trig |-> ##FAST_DELAY_CYCLES held_then_low)
    else $error("bad fast reset delay");
  kbd_delay_a: assert property (kbd_trig |-> ##KBD_DELAY_CYCLES held_then_low)
    else $error("bad keyboard reset delay");
  pulse_len_a: assert property (
    $rose(processor_reset_n) && !hold_s |-> low_cnt == PULSE_CYCLES)
    else $error("bad reset pulse length");
  hold_low_a: assert property (hold_s |=> !processor_reset_n)
    else $error("reset not held");
  flash_en_a: assert property ({flash_read_enable, flash_write_enable} == cfg_s[28:27])
    else $error("bad flash enables");
  cas_sel_a: assert property (
    dram_timing.cas_rd_low == (cfg_s[22] ? 2'h1 : 2'h2)
    && dram_timing.cas_wr_low == (cfg_s[23] ? 2'h1 : 2'h2)
    && dram_timing.vl_extra_setup == !cfg_s[25])
    else $error("bad cas select");
  ras_slow_a: assert property (
    !cfg_s[SCS_CFG_MEM80] |-> dram_timing.ras_low == ((cfg_s[9:8] == SCS_CLK_25) ? 3'h3 : 3'h4))
    else $error("bad ras time");
  reset_dflt_a: assert property (
    $rose(rst_n) |-> nmi_n && processor_reset_n && !address_line20_gate && !speaker_enable
    && dram_timing.vl_extra_setup)
    else $error("bad reset defaults");
endmodule

bind scs_system_config scs_system_config_assertions #(
  .KBD_DELAY_CYCLES(KBD_DELAY_CYCLES),
  .FAST_DELAY_CYCLES(FAST_DELAY_CYCLES),
  .PULSE_CYCLES(PULSE_CYCLES)
) u_sva (.*);

// *** dv/scs_system_config_test.sv ***
// self-checking bench for the configuration word and legacy port block
// assumes short delay parameters; the host model drives all host cycles
`timescale 1ns/1ps
module scs_system_config_test;
  import scs_pkg::*;
  localparam int KD = 4;
  localparam int FD = 6;
  localparam int PW = 3;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  scs_host_req_type host_req;
  logic host_ack, host_forward, nmi_n, address_line20_gate, processor_reset_n;
  logic speaker_enable, timer2_gate, flash_write_enable, flash_read_enable;
  logic [31:0] host_rdata;
  logic isa_io_write = 1'b0, mem_parity_error = 1'b0, isa_channel_check = 1'b0;
  logic [15:0] isa_io_addr = 16'h0000;
  logic [7:0] isa_io_data = 8'h00;
  logic isa_refresh = 1'b0, timer2_output = 1'b0, turbo_mode = 1'b0;
  scs_dram_timing_type dram_timing;
  int errors = 0;
  int comparisons = 0;
  logic [31:0] words [5] = '{32'h00000300, 32'h00401300, 32'h08801200, 32'h12001100,
    32'h02C00000};
  always #12.5 clock = ~clock;
  scs_system_config #(.KBD_DELAY_CYCLES(KD), .FAST_DELAY_CYCLES(FD), .PULSE_CYCLES(PW)) uut (.*);
  scs_host_model host (.*);
  // ----------
  // helpers
  // ----------
  task automatic check(input string n, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("BAD %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task automatic stop_test();
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic io(input logic [7:0] p, input logic [7:0] d);
    host.cycle(1'b1, 1'b1, {24'h0, p}, {24'h0, d});
  endtask
  task automatic rd(input string n, input logic io_c, input logic [31:0] ad,
    input logic [31:0] exp, input logic fwd);
    host.cycle(io_c, 1'b0, ad, 32'h0);
    check({n, " ack"}, {31'h0, host.ack_seen}, 32'h1);
    check({n, " fwd"}, {31'h0, host.fwd_seen}, {31'h0, fwd});
    check(n, host.rd_seen, exp);
  endtask
  task automatic isa_wr(input logic [7:0] d);
    @(negedge clock);
    isa_io_write <= 1'b1;
    isa_io_addr <= SCS_PORT_NMI_MASK;
    isa_io_data <= d;
    @(negedge clock);
    isa_io_write <= 1'b0;
    isa_io_addr <= ~SCS_PORT_NMI_MASK;
    isa_io_data <= ~d;
  endtask
  task automatic ev(input logic [2:0] e);
    @(negedge clock);
    {mem_parity_error, isa_channel_check, isa_refresh} <= e;
    @(negedge clock);
    {mem_parity_error, isa_channel_check, isa_refresh} <= 3'h0;
  endtask
  // k counts cycles after the triggering write
  task automatic watch_reset(input int d);
    for (int k = 0; k <= d + PW + 1; k++) begin
      check("reset out", {31'h0, processor_reset_n}, (k >= d && k < d + PW) ? 0 : 1);
      @(negedge clock);
    end
  endtask
  function automatic logic [31:0] exp_timing(input logic [31:0] w);
    logic [2:0] lo, hi;
    lo = (w[9:8] == SCS_CLK_25) ? 3'h3 : 3'h4;
    hi = lo;
    if (w[12]) begin
      lo = (w[9:8] == SCS_CLK_25) ? 3'h2 : (w[9:8] == SCS_CLK_33) ? 3'h3 : 3'h4;
      hi = (w[9:8] == SCS_CLK_25) ? 3'h2 : 3'h3;
    end
    return {14'h0, lo, hi, hi, (w[22] ? 2'h1 : 2'h2), 2'h1, (w[23] ? 2'h1 : 2'h2), 2'h1, !w[25]};
  endfunction
  // ----------
  // tests
  // ----------
  initial begin
    repeat (20) @(negedge clock);
    rst_n <= 1'b1;
    check("nmi_n", {31'h0, nmi_n}, 32'h1);
    check("timing", 32'(dram_timing), exp_timing(32'h0));
    rd("cfg", 1'b0, SCS_CFG_ADDR, 32'h0, 1'b0);
    rd("p61", 1'b1, 32'h61, 32'h0, 1'b0);
    rd("p92 off", 1'b1, 32'h92, 32'h0, 1'b1);
    rd("unmapped", 1'b0, SCS_CFG_ADDR + 32'h4, 32'h0, 1'b1);
    foreach (words[i]) begin
      host.cfg_write(words[i]);
      rd("cfg", 1'b0, SCS_CFG_ADDR, host.cfg_last, 1'b0);
      check("timing", 32'(dram_timing), exp_timing(host.cfg_last));
      check("flash", {30'h0, flash_read_enable, flash_write_enable}, {30'h0, host.cfg_last[28:27]});
    end
    host.cfg_write(32'h0000C000);
    io(8'h92, 8'h02);
    check("a20", {31'h0, address_line20_gate}, 32'h1);
    turbo_mode <= 1'b1;
    rd("p92", 1'b1, 32'h92, 32'h3E, 1'b0);
    isa_wr(8'h80);
    turbo_mode <= 1'b0;
    rd("p92 masked", 1'b1, 32'h92, 32'h32, 1'b0);
    ev(3'h4);
    check("nmi masked", {31'h0, nmi_n}, 32'h1);
    isa_wr(8'h00);
    @(negedge clock);
    check("nmi", {31'h0, nmi_n}, 32'h0);
    io(8'h61, 8'h03);
    check("spk gate", {30'h0, speaker_enable, timer2_gate}, 32'h3);
    timer2_output <= 1'b1;
    ev(3'h3);
    rd("p61", 1'b1, 32'h61, 32'hF3, 1'b0);
    rd("p61 again", 1'b1, 32'h61, 32'hE3, 1'b0);
    io(8'h61, 8'h0F);
    rd("p61 off", 1'b1, 32'h61, 32'h2F, 1'b0);
    check("nmi off", {31'h0, nmi_n}, 32'h1);
    io(8'h92, 8'h03);
    watch_reset(FD);
    io(8'h92, 8'h00);
    check("a20 off", {31'h0, address_line20_gate}, 32'h0);
    io(8'h64, 8'hD1);
    io(8'h60, 8'h03);
    check("kbd a20", {31'h0, address_line20_gate}, 32'h1);
    io(8'h64, 8'hFE);
    check("fwd 64h", {31'h0, host.fwd_seen}, 32'h1);
    watch_reset(KD);
    io(8'h64, 8'hD1);
    io(8'h60, 8'h00);
    check("kbd a20 off", {31'h0, address_line20_gate}, 32'h0);
    repeat (2) @(negedge clock);
    for (int k = 0; k < 4 * PW; k++) begin
      check("reset held", {31'h0, processor_reset_n}, 32'h0);
      @(negedge clock);
    end
    stop_test();
  end
  // the whole run takes under a thousand cycles
  initial begin
    repeat (5000) @(posedge clock);
    errors++;
    stop_test();
  end
endmodule

// *** rtl/scs_dram_timing.sv ***
// memory and local bus timing selects decoded from the configuration word
// assumes the sequencers outside take the clock counts as minimums
`timescale 1ns/1ps
module scs_dram_timing (
  // configuration
  input wire logic [1:0] clock_speed,
  input wire logic mem80,
  input wire logic fast_read,
  input wire logic fast_write,
  input wire logic fast_vl,
  // timing selects
  output scs_pkg::scs_dram_timing_type timing
);
  import scs_pkg::*;

  always_comb begin
    timing = '0;
    if (mem80) begin
      unique case (clock_speed)
        SCS_CLK_25: begin
          timing.ras_low = 3'h2;
          timing.ras_high = 3'h2;
          timing.ras_precharge = 3'h2;
        end
        SCS_CLK_33: begin
          timing.ras_low = 3'h3;
          timing.ras_high = 3'h3;
          timing.ras_precharge = 3'h3;
        end
        default: begin
          timing.ras_low = 3'h4;
          timing.ras_high = 3'h3;
          timing.ras_precharge = 3'h3;
        end
      endcase
    end else begin
      if (clock_speed == SCS_CLK_25) begin
        timing.ras_low = 3'h3;
        timing.ras_high = 3'h3;
        timing.ras_precharge = 3'h3;
      end else begin
        timing.ras_low = 3'h4;
        timing.ras_high = 3'h4;
        timing.ras_precharge = 3'h4;
      end
    end
    timing.cas_rd_low = fast_read ? 2'h1 : 2'h2;
    timing.cas_rd_high = 2'h1;
    timing.cas_wr_low = fast_write ? 2'h1 : 2'h2;
    timing.cas_wr_high = 2'h1;
    timing.vl_extra_setup = ~fast_vl;
  end

endmodule

// *** rtl/scs_pkg.sv ***
// package for the system configuration and legacy port block
// assumes one 40 MHz clock and a synchronous active-low reset
package scs_pkg;

  // ----------------------------------------------------------------
  // addresses
  // ----------------------------------------------------------------
  localparam logic [31:0] SCS_CFG_ADDR = 32'hFF00401C;
  localparam logic [15:0] SCS_PORT_KBD_DATA = 16'h0060;
  localparam logic [15:0] SCS_PORT_MISC = 16'h0061;
  localparam logic [15:0] SCS_PORT_KBD_CMD = 16'h0064;
  localparam logic [15:0] SCS_PORT_NMI_MASK = 16'h0070;
  localparam logic [15:0] SCS_PORT_FAST_SYS = 16'h0092;

  // ----------------------------------------------------------------
  // configuration word fields
  // ----------------------------------------------------------------
  localparam int SCS_CFG_CLK_LO = 8;
  localparam int SCS_CFG_MEM80 = 12;
  localparam int SCS_CFG_P92_EN = 14;
  localparam int SCS_CFG_PARITY_EN = 15;
  localparam int SCS_CFG_FAST_RD = 22;
  localparam int SCS_CFG_FAST_WR = 23;
  localparam int SCS_CFG_FAST_VL = 25;
  localparam int SCS_CFG_FLASH_WR = 27;
  localparam int SCS_CFG_FLASH_RD = 28;
  localparam logic [31:0] SCS_CFG_RESET = 32'h00000000;

  // clock speed field codes
  localparam logic [1:0] SCS_CLK_50 = 2'h0;
  localparam logic [1:0] SCS_CLK_40 = 2'h1;
  localparam logic [1:0] SCS_CLK_33 = 2'h2;
  localparam logic [1:0] SCS_CLK_25 = 2'h3;

  // ----------------------------------------------------------------
  // port bit positions
  // ----------------------------------------------------------------
  localparam int SCS_P61_PARITY = 7;
  localparam int SCS_P61_CHANCHK = 6;
  localparam int SCS_P61_TIMER2 = 5;
  localparam int SCS_P61_REFRESH = 4;
  localparam int SCS_P61_CHANCHK_DIS = 3;
  localparam int SCS_P61_PARITY_DIS = 2;
  localparam int SCS_P61_SPEAKER = 1;
  localparam int SCS_P61_GATE2 = 0;
  localparam logic [3:0] SCS_P61_CTL_RESET = 4'h0;
  localparam int SCS_P70_MASK = 7;
  localparam int SCS_P92_RSV_HI = 5;
  localparam int SCS_P92_RSV_LO = 4;
  localparam int SCS_P92_NMI_EN = 3;
  localparam int SCS_P92_TURBO = 2;
  localparam int SCS_P92_A20 = 1;
  localparam int SCS_P92_RESET = 0;

  // keyboard commands
  localparam logic [7:0] SCS_KBD_CMD_WRITE_OUT = 8'hD1;
  localparam logic [3:0] SCS_KBD_RESET_HI = 4'hF;
  localparam int SCS_KBD_GATE_BIT = 1;
  localparam int SCS_KBD_RESET_BIT = 0;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int SCS_CLK_PERIOD_PS = 25000;
  localparam int SCS_KBD_DELAY_PS = 6720000;
  localparam int SCS_KBD_DELAY_CYCLES =
    (SCS_KBD_DELAY_PS + SCS_CLK_PERIOD_PS - 1) / SCS_CLK_PERIOD_PS;
  localparam int SCS_FAST_DELAY_CYCLES = 288;
  localparam int SCS_RESET_PULSE_CYCLES = 32;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic valid;
    logic is_io;
    logic write;
    logic [31:0] addr;
    logic [31:0] wdata;
  } scs_host_req_type;

  typedef struct packed {
    logic [2:0] ras_low;
    logic [2:0] ras_high;
    logic [2:0] ras_precharge;
    logic [1:0] cas_rd_low;
    logic [1:0] cas_rd_high;
    logic [1:0] cas_wr_low;
    logic [1:0] cas_wr_high;
    logic vl_extra_setup;
  } scs_dram_timing_type;

  typedef enum logic [2:0] {
    SCS_SEQ_IDLE = 3'b001,
    SCS_SEQ_WAIT = 3'b010,
    SCS_SEQ_PULSE = 3'b100
  } scs_seq_state_type;

endpackage

// *** rtl/scs_reset_seq.sv ***
// delayed fixed-length reset pulse: wait, then assert for a count
// assumes trigger is a one-cycle pulse; triggers while busy are ignored
`timescale 1ns/1ps
module scs_reset_seq #(
  parameter int DELAY_CYCLES = 288,
  parameter int PULSE_CYCLES = 32
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // control
  input wire logic trigger,
  output logic active
);
  import scs_pkg::*;

  localparam int CW = $clog2(DELAY_CYCLES + PULSE_CYCLES + 1);
  localparam logic [CW-1:0] DELAY_LAST = CW'(DELAY_CYCLES - 1);
  localparam logic [CW-1:0] PULSE_LAST = CW'(PULSE_CYCLES - 1);

  scs_seq_state_type state;
  scs_seq_state_type next_state;
  logic [CW-1:0] count;
  logic [CW-1:0] next_count;

  always_comb begin
    next_state = state;
    next_count = count;
    unique case (state)
      SCS_SEQ_IDLE: begin
        next_count = '0;
        if (trigger) begin
          next_state = SCS_SEQ_WAIT;
        end
      end
      SCS_SEQ_WAIT: begin
        next_count = count + CW'(1);
        if (count == DELAY_LAST) begin
          next_state = SCS_SEQ_PULSE;
          next_count = '0;
        end
      end
      SCS_SEQ_PULSE: begin
        next_count = count + CW'(1);
        if (count == PULSE_LAST) begin
          next_state = SCS_SEQ_IDLE;
          next_count = '0;
        end
      end
      default: begin
        next_state = SCS_SEQ_IDLE;
        next_count = '0;
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      state <= SCS_SEQ_IDLE;
      count <= '0;
    end else begin
      state <= next_state;
      count <= next_count;
    end
  end

  assign active = (state == SCS_SEQ_PULSE);

endmodule

// *** rtl/scs_system_config.sv ***
// configuration word, legacy ports 61h/70h/92h and keyboard shadowing
// assumes host cycles arrive as one-cycle requests synchronous to clock
`timescale 1ns/1ps

// Behaviour
// - slow memory: RAS times 3 or 4 clocks
// - bit 14 claims port 92h, else forward
// - parity errors raise NMI when both enabled
// - bit 22 selects read CAS timing
// - bit 23 selects write CAS timing
// - bit 25 clear adds VL setup delays
// - flash writes and reads gated by bits
// - port 61h read-only status bits 7..4
// - port 61h read/write bits 3..0, reset zero
// - port 70h bit 7 masks NMI, snooped
// - port 92h bit 3 reads NMI enable
// - port 92h read-only status and ones
// - port 92h fast A20 bit drives gate
// - fast reset: 288 clocks wait, 32 pulse
// - D1 then data write sets keyboard gate
// - command 1111xxx0 delayed keyboard reset pulse
// - D1 then bit0 zero holds reset
// - configuration word at 0xFF00401C
// - 80ns memory: RAS low 2/3/4 clocks
module scs_system_config #(
  parameter int KBD_DELAY_CYCLES = scs_pkg::SCS_KBD_DELAY_CYCLES,
  parameter int FAST_DELAY_CYCLES = scs_pkg::SCS_FAST_DELAY_CYCLES,
  parameter int PULSE_CYCLES = scs_pkg::SCS_RESET_PULSE_CYCLES
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // host cycles
  input scs_pkg::scs_host_req_type host_req,
  output logic host_ack,
  output logic host_forward,
  output logic [31:0] host_rdata,
  // isa snoop
  input wire logic isa_io_write,
  input wire logic [15:0] isa_io_addr,
  input wire logic [7:0] isa_io_data,
  // events and status inputs
  input wire logic mem_parity_error,
  input wire logic isa_channel_check,
  input wire logic isa_refresh,
  input wire logic timer2_output,
  input wire logic turbo_mode,
  // system outputs
  output logic nmi_n,
  output logic address_line20_gate,
  output logic processor_reset_n,
  output logic speaker_enable,
  output logic timer2_gate,
  output logic flash_write_enable,
  output logic flash_read_enable,
  output scs_pkg::scs_dram_timing_type dram_timing
);
  import scs_pkg::*;

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  function automatic logic io_hit(input scs_host_req_type r, input logic [15:0] port);
    io_hit = r.valid && r.is_io && (r.addr[15:0] == port) && (r.addr[31:16] == 16'h0000);
  endfunction

  logic [31:0] cfg;
  logic [31:0] next_cfg;
  logic [3:0] p61_ctl;
  logic [3:0] next_p61_ctl;
  logic parity_flag;
  logic next_parity_flag;
  logic chanchk_flag;
  logic next_chanchk_flag;
  logic refresh_flag;
  logic next_refresh_flag;
  logic nmi_mask;
  logic next_nmi_mask;
  logic fast_a20;
  logic next_fast_a20;
  logic fast_reset;
  logic next_fast_reset;
  logic kbd_pending;
  logic next_kbd_pending;
  logic keyboard_gate_shadow;
  logic next_keyboard_gate_shadow;
  logic kbd_hold;
  logic next_kbd_hold;
  logic ack;
  logic next_ack;
  logic fwd;
  logic next_fwd;
  logic [31:0] rdata;
  logic [31:0] next_rdata;
  logic nmi_q;
  logic next_nmi_q;

  logic hit_cfg;
  logic hit_p60;
  logic hit_p61;
  logic hit_p64;
  logic hit_p70;
  logic hit_p92;
  logic claim;
  logic wr;
  logic [7:0] wbyte;
  logic keyboard_reset_pulse;
  logic fast_reset_trigger;
  logic fast_active;
  logic kbd_active;
  logic [7:0] p61_value;
  logic [7:0] p92_value;

  always_comb begin
    hit_cfg = host_req.valid && !host_req.is_io && (host_req.addr == SCS_CFG_ADDR);
    hit_p60 = io_hit(host_req, SCS_PORT_KBD_DATA);
    hit_p61 = io_hit(host_req, SCS_PORT_MISC);
    hit_p64 = io_hit(host_req, SCS_PORT_KBD_CMD);
    hit_p70 = io_hit(host_req, SCS_PORT_NMI_MASK);
    hit_p92 = io_hit(host_req, SCS_PORT_FAST_SYS) && cfg[SCS_CFG_P92_EN];
    claim = hit_cfg || hit_p61 || hit_p92;
    wr = host_req.write;
    wbyte = host_req.wdata[7:0];
  end

  // ----------------------------------------------------------------
  // read values
  // ----------------------------------------------------------------
  always_comb begin
    p61_value = {parity_flag, chanchk_flag, timer2_output, refresh_flag, p61_ctl};
    p92_value = 8'h00;
    p92_value[SCS_P92_RSV_HI] = 1'b1;
    p92_value[SCS_P92_RSV_LO] = 1'b1;
    p92_value[SCS_P92_NMI_EN] = ~nmi_mask;
    p92_value[SCS_P92_TURBO] = turbo_mode;
    p92_value[SCS_P92_A20] = fast_a20;
    p92_value[SCS_P92_RESET] = fast_reset;
  end

  // ----------------------------------------------------------------
  // register next values
  // ----------------------------------------------------------------
  always_comb begin
    next_cfg = cfg;
    next_p61_ctl = p61_ctl;
    next_nmi_mask = nmi_mask;
    next_fast_a20 = fast_a20;
    next_fast_reset = fast_reset;
    next_kbd_pending = kbd_pending;
    next_keyboard_gate_shadow = keyboard_gate_shadow;
    next_kbd_hold = kbd_hold;
    keyboard_reset_pulse = 1'b0;
    fast_reset_trigger = 1'b0;
    next_ack = host_req.valid;
    next_fwd = host_req.valid && !claim;
    next_rdata = 32'h00000000;

    // reserved bits are stored as written; software keeps them legal
    if (hit_cfg && wr) begin
      next_cfg = host_req.wdata;
    end
    if (hit_p61 && wr) begin
      next_p61_ctl = wbyte[3:0];
    end
    if (hit_p70 && wr) begin
      next_nmi_mask = wbyte[SCS_P70_MASK];
    end
    if (isa_io_write && (isa_io_addr == SCS_PORT_NMI_MASK)) begin
      next_nmi_mask = isa_io_data[SCS_P70_MASK];
    end
    if (hit_p92 && wr) begin
      next_fast_a20 = wbyte[SCS_P92_A20];
      next_fast_reset = wbyte[SCS_P92_RESET];
      fast_reset_trigger = wbyte[SCS_P92_RESET];
    end

    // keyboard controller shadowing
    if (hit_p64 && wr) begin
      next_kbd_pending = (wbyte == SCS_KBD_CMD_WRITE_OUT);
      if (wbyte[7:4] == SCS_KBD_RESET_HI && !wbyte[0]) begin
        keyboard_reset_pulse = 1'b1;
      end
    end
    if (hit_p60 && wr && kbd_pending) begin
      next_kbd_pending = 1'b0;
      next_keyboard_gate_shadow = wbyte[SCS_KBD_GATE_BIT];
      next_kbd_hold = ~wbyte[SCS_KBD_RESET_BIT];
    end

    if (host_req.valid && !wr) begin
      if (hit_cfg) begin
        next_rdata = cfg;
      end else if (hit_p61) begin
        next_rdata = {24'h000000, p61_value};
      end else if (hit_p92) begin
        next_rdata = {24'h000000, p92_value};
      end
    end
  end

  // ----------------------------------------------------------------
  // sticky status flags: a refresh set during a clearing read wins
  // ----------------------------------------------------------------
  always_comb begin
    next_parity_flag = parity_flag;
    next_chanchk_flag = chanchk_flag;
    next_refresh_flag = refresh_flag;
    // disabling a check clears its flag
    if (p61_ctl[SCS_P61_PARITY_DIS]) begin
      next_parity_flag = 1'b0;
    end
    if (p61_ctl[SCS_P61_CHANCHK_DIS]) begin
      next_chanchk_flag = 1'b0;
    end
    // reading port 61h clears the refresh flag
    if (hit_p61 && !wr) begin
      next_refresh_flag = 1'b0;
    end
    if (mem_parity_error && !p61_ctl[SCS_P61_PARITY_DIS]) begin
      next_parity_flag = 1'b1;
    end
    if (isa_channel_check && !p61_ctl[SCS_P61_CHANCHK_DIS]) begin
      next_chanchk_flag = 1'b1;
    end
    if (isa_refresh) begin
      next_refresh_flag = 1'b1;
    end
    next_nmi_q = cfg[SCS_CFG_PARITY_EN] && !nmi_mask && parity_flag;
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      cfg <= SCS_CFG_RESET;
      p61_ctl <= SCS_P61_CTL_RESET;
      parity_flag <= 1'b0;
      chanchk_flag <= 1'b0;
      refresh_flag <= 1'b0;
      nmi_mask <= 1'b0;
      fast_a20 <= 1'b0;
      fast_reset <= 1'b0;
      kbd_pending <= 1'b0;
      keyboard_gate_shadow <= 1'b0;
      kbd_hold <= 1'b0;
      ack <= 1'b0;
      fwd <= 1'b0;
      rdata <= 32'h00000000;
      nmi_q <= 1'b0;
    end else begin
      cfg <= next_cfg;
      p61_ctl <= next_p61_ctl;
      parity_flag <= next_parity_flag;
      chanchk_flag <= next_chanchk_flag;
      refresh_flag <= next_refresh_flag;
      nmi_mask <= next_nmi_mask;
      fast_a20 <= next_fast_a20;
      fast_reset <= next_fast_reset;
      kbd_pending <= next_kbd_pending;
      keyboard_gate_shadow <= next_keyboard_gate_shadow;
      kbd_hold <= next_kbd_hold;
      ack <= next_ack;
      fwd <= next_fwd;
      rdata <= next_rdata;
      nmi_q <= next_nmi_q;
    end
  end

  // ----------------------------------------------------------------
  // processor reset sources
  // ----------------------------------------------------------------
  scs_reset_seq #(
    .DELAY_CYCLES(FAST_DELAY_CYCLES),
    .PULSE_CYCLES(PULSE_CYCLES)
  ) u_fast_reset (
    .clock(clock),
    .rst_n(rst_n),
    .trigger(fast_reset_trigger),
    .active(fast_active)
  );

  scs_reset_seq #(
    .DELAY_CYCLES(KBD_DELAY_CYCLES),
    .PULSE_CYCLES(PULSE_CYCLES)
  ) u_kbd_reset (
    .clock(clock),
    .rst_n(rst_n),
    .trigger(keyboard_reset_pulse),
    .active(kbd_active)
  );

  // ----------------------------------------------------------------
  // timing selects
  // ----------------------------------------------------------------
  scs_dram_timing u_timing (
    .clock_speed(cfg[SCS_CFG_CLK_LO +: 2]),
    .mem80(cfg[SCS_CFG_MEM80]),
    .fast_read(cfg[SCS_CFG_FAST_RD]),
    .fast_write(cfg[SCS_CFG_FAST_WR]),
    .fast_vl(cfg[SCS_CFG_FAST_VL]),
    .timing(dram_timing)
  );

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign host_ack = ack;
  assign host_forward = fwd;
  assign host_rdata = rdata;
  assign nmi_n = ~nmi_q;
  assign address_line20_gate = fast_a20 | keyboard_gate_shadow;
  assign processor_reset_n = ~(fast_active | kbd_active | kbd_hold);
  assign speaker_enable = p61_ctl[SCS_P61_SPEAKER];
  assign timer2_gate = p61_ctl[SCS_P61_GATE2];
  assign flash_write_enable = cfg[SCS_CFG_FLASH_WR];
  assign flash_read_enable = cfg[SCS_CFG_FLASH_RD];

endmodule
